/* File: shared/touch_sar_regs.svh */
`ifndef TOUCH_SAR_REGS_SVH
`define TOUCH_SAR_REGS_SVH

// Conversion control register, 8 bits
`define CONV_CTRL_RESET      8'h00
`define CONV_CTRL_TRIG_BIT   7
`define CONV_CTRL_RSVD_BIT   6
`define CONV_CTRL_MODE_HI    5
`define CONV_CTRL_MODE_LO    2
`define CONV_CTRL_IRQ_HI     1
`define CONV_CTRL_IRQ_LO     0

// Mode codes
`define MODE_NONE            4'h0
`define MODE_XY              4'h1
`define MODE_XYZ             4'h2
`define MODE_X               4'h3
`define MODE_Y               4'h4
`define MODE_Z               4'h5
`define MODE_BAT             4'h6
`define MODE_AUX_INPUT_TWO            4'h7
`define MODE_AUTO            4'h9
`define MODE_TEMP_SENSE_ONE           4'hA
`define MODE_PORT            4'hB
`define MODE_TEMP_SENSE_TWO           4'hC

// Interrupt select codes
`define IRQ_SEL_PEN          2'h0
`define IRQ_SEL_READY        2'h1
`define IRQ_SEL_BOTH         2'h2

// Enable bit positions for auto scan inputs
`define AUTO_EN_AUX_INPUT_ONE         0
`define AUTO_EN_AUX_INPUT_TWO         1
`define AUTO_EN_BAT          2

`endif

/* File: shared/touch_sar_pkg.sv */
package touch_sar_pkg;

    typedef enum logic [3:0] {
        CH_X    = 4'h0,
        CH_Y    = 4'h1,
        CH_ZA   = 4'h2,
        CH_ZB   = 4'h3,
        CH_BAT  = 4'h4,
        CH_AUX_INPUT_ONE = 4'h5,
        CH_AUX_INPUT_TWO = 4'h6,
        CH_T1   = 4'h7,
        CH_T2   = 4'h8
    } channel_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_CONV = 4'b0010,
        ST_NEXT = 4'b0100,
        ST_DONE = 4'b1000
    } seq_state_t;

endpackage : touch_sar_pkg

/* File: hw/irq_pin_mux.sv */
`timescale 1ns/100ps
`include "touch_sar_regs.svh"

module irq_pin_mux
    import touch_sar_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    input  wire logic [1:0] irq_sel,
    input  wire logic       pen_touch_irq,
    input  wire logic       result_ready_irq,
    output logic            irq_pin
);

    // Registered pin; idle level follows the selected polarity
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            irq_pin <= 1'b1;
        else
        begin
            case (irq_sel)
                `IRQ_SEL_PEN:   irq_pin <= ~pen_touch_irq;                      // R16
                `IRQ_SEL_READY: irq_pin <= ~result_ready_irq;                   // R16
                `IRQ_SEL_BOTH:  irq_pin <= pen_touch_irq | result_ready_irq;    // R17
                default:        irq_pin <= 1'b1;                                // R17
            endcase
        end
    end

endmodule : irq_pin_mux

/* File: hw/touch_sar_conversion_control.sv */
`timescale 1ns/100ps
`include "touch_sar_regs.svh"
// What this block does
// [R1] Trigger bit 0: host starts conversions; 1: pen touch starts touch scans.
// [R2] Software writes zero to reserved bit six.
// [R3] Mode 0000 performs no scan or measurement.
// [R4] Mode 0001 repeats X then Y until pen lift or stop.
// [R5] Mode 0010 repeats X, Y, both pressures until pen lift or stop.
// [R6] Mode 0011 repeats X only, pen-triggered only.
// [R7] Mode 0100 repeats Y only, pen-triggered only.
// [R8] Mode 0101 repeats both pressures only, pen-triggered only.
// [R9] Mode 0110 measures battery once.
// [R10] Mode 0111 measures second auxiliary once.
// [R11] Mode 1001 auto scans aux_input_one, aux_input_two, battery, skipping disabled ones, until stop/change.
// [R12] Mode 1010 measures first temperature configuration.
// [R13] Mode 1011 port scans aux_input_one, aux_input_two, battery once.
// [R14] Mode 1100 measures second temperature configuration.
// [R15] Software never writes reserved mode codes.
// [R16] Irq select 00: pen touch active low; 01: result ready active low.
// [R17] Irq select 10: both events active high; 11 reserved.
// [R18] Stop bit halts conversion and powers the converter down.
// [R19] Result ready pulses when each result is written.

module touch_sar_conversion_control
    import touch_sar_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic       host_start,
    input  wire logic       stop_req,
    input  wire logic [2:0] auto_enable,
    input  wire logic       pen_down_pin,
    output logic            conv_start,
    output logic      [3:0] conv_channel,
    input  wire logic       conv_done,
    output logic            sar_power_on,
    output logic            result_ready_irq,
    output logic            pen_touch_irq,
    output logic            scan_busy,
    output logic            general_pin_one
);

    logic [7:0]  ctrl_q;
    logic        pen_meta_q;
    logic        pen_sync_q;
    logic        pen_prev_q;
    seq_state_t  state_q;
    logic [2:0]  step_q;
    logic        pen_rise;
    logic [3:0]  mode;
    logic        trig_pen;
    logic        continuous;
    logic        touch_mode;
    logic        start_ok;
    logic [1:0]  irq_sel;

    assign mode     = ctrl_q[`CONV_CTRL_MODE_HI:`CONV_CTRL_MODE_LO];
    assign trig_pen = ctrl_q[`CONV_CTRL_TRIG_BIT];
    assign reg_rdata = ctrl_q;
    assign irq_sel  = ctrl_q[`CONV_CTRL_IRQ_HI:`CONV_CTRL_IRQ_LO];

    // Channel for a step of the current mode; NONE-like result ends the sequence (restarts the pass in continuous modes) unless it marks a disabled auto scan input
    function automatic logic [4:0] step_channel(input logic [3:0] m, input logic [2:0] s,
                                                input logic [2:0] en);
        step_channel = 5'h10;
        case (m)
            `MODE_XY:    if (s < 3'h2) step_channel = {1'b0, (s == 3'h0) ? CH_X : CH_Y}; // R4
            `MODE_XYZ:                                                                   // R5
                case (s)
                    3'h0:    step_channel = {1'b0, CH_X};
                    3'h1:    step_channel = {1'b0, CH_Y};
                    3'h2:    step_channel = {1'b0, CH_ZA};
                    3'h3:    step_channel = {1'b0, CH_ZB};
                    default: step_channel = 5'h10;
                endcase
            `MODE_X:     if (s == 3'h0) step_channel = {1'b0, CH_X};                    // R6
            `MODE_Y:     if (s == 3'h0) step_channel = {1'b0, CH_Y};                    // R7
            `MODE_Z:     if (s < 3'h2) step_channel = {1'b0, (s == 3'h0) ? CH_ZA : CH_ZB}; // R8
            `MODE_BAT:   if (s == 3'h0) step_channel = {1'b0, CH_BAT};                  // R9
            `MODE_AUX_INPUT_TWO:  if (s == 3'h0) step_channel = {1'b0, CH_AUX_INPUT_TWO};                 // R10
            `MODE_TEMP_SENSE_ONE: if (s == 3'h0) step_channel = {1'b0, CH_T1};                   // R12
            `MODE_TEMP_SENSE_TWO: if (s == 3'h0) step_channel = {1'b0, CH_T2};                   // R14
            `MODE_PORT, `MODE_AUTO:                                                     // R11 R13
                case (s)
                    3'h0:    if (m == `MODE_PORT || en[`AUTO_EN_AUX_INPUT_ONE])
                                 step_channel = {1'b0, CH_AUX_INPUT_ONE};
                    3'h1:    if (m == `MODE_PORT || en[`AUTO_EN_AUX_INPUT_TWO])
                                 step_channel = {1'b0, CH_AUX_INPUT_TWO};
                    3'h2:    if (m == `MODE_PORT || en[`AUTO_EN_BAT])
                                 step_channel = {1'b0, CH_BAT};
                    default: step_channel = 5'h10;
                endcase
            default:     step_channel = 5'h10;                                          // R3
        endcase
    endfunction : step_channel

    // Register write; reserved bit kept at zero by software, stored as written
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            ctrl_q <= `CONV_CTRL_RESET;
        else if (reg_wr)
            ctrl_q <= reg_wdata;                                                        // R2
    end

    // Pen pin crosses from the panel comparator
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            pen_meta_q <= 1'b0;
            pen_sync_q <= 1'b0;
            pen_prev_q <= 1'b0;
        end
        else
        begin
            pen_meta_q <= pen_down_pin;
            pen_sync_q <= pen_meta_q;
            pen_prev_q <= pen_sync_q;
        end
    end

    assign pen_rise      = pen_sync_q & ~pen_prev_q;
    assign pen_touch_irq = pen_sync_q;
    assign touch_mode    = (mode >= `MODE_XY) && (mode <= `MODE_Z);
    assign continuous    = touch_mode || (mode == `MODE_AUTO);
    // Touch-only modes require pen triggering; host starts nothing then
    assign start_ok = trig_pen ? (touch_mode && pen_rise)                              // R1
                               : (host_start && mode != `MODE_NONE &&
                                  !(mode >= `MODE_X && mode <= `MODE_Z));               // R1 R6 R7 R8

    // Sequencer
    logic        abort;
    logic [4:0]  cur_ch;
    logic        auto_skip;
    logic        auto_none;
    assign cur_ch = step_channel(mode, step_q, auto_enable);
    // Auto scan steps over a disabled input; with none enabled it returns to idle from ST_NEXT without a conversion
    assign auto_skip = (mode == `MODE_AUTO) && (step_q < 3'h3) && (auto_enable != 3'h0);
    assign auto_none = (mode == `MODE_AUTO) && (auto_enable == 3'h0);
    // Touch scans end on pen lift; auto scan on mode change; all on stop
    assign abort = stop_req || (touch_mode && !pen_sync_q) ||                           // R18 R4 R5
                   (reg_wr && reg_wdata[`CONV_CTRL_MODE_HI:`CONV_CTRL_MODE_LO] != mode); // R11

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            state_q      <= ST_IDLE;
            step_q       <= 3'h0;
            conv_channel <= 4'h0;
        end
        else if (abort && state_q != ST_IDLE)
        begin
            state_q <= ST_IDLE;                                                         // R18
            step_q  <= 3'h0;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                    if (start_ok && !stop_req)
                    begin
                        step_q  <= 3'h0;
                        state_q <= ST_NEXT;
                    end
                ST_NEXT:
                    if (cur_ch[4])
                    begin
                        if (auto_skip)
                            step_q <= step_q + 3'h1;                                    // R11
                        else if (step_q == 3'h0 || auto_none)
                            state_q <= ST_IDLE;                   // Nothing enabled
                        else if (continuous)
                            step_q <= 3'h0;                                             // R4 R11
                        else
                            state_q <= ST_DONE;
                    end
                    else
                    begin
                        conv_channel <= cur_ch[3:0];
                        state_q      <= ST_CONV;
                    end
                ST_CONV:
                    if (conv_done)
                    begin
                        step_q  <= step_q + 3'h1;
                        state_q <= ST_NEXT;
                    end
                ST_DONE:
                    state_q <= ST_IDLE;
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // Start pulse and result flag
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            conv_start       <= 1'b0;
            result_ready_irq <= 1'b0;
        end
        else
        begin
            conv_start       <= (state_q == ST_NEXT) && !cur_ch[4] && !abort;
            result_ready_irq <= (state_q == ST_CONV) && conv_done && !abort;             // R19
        end
    end

    assign scan_busy    = (state_q != ST_IDLE);
    assign sar_power_on = scan_busy && !stop_req;                                       // R18

    irq_pin_mux u_irq
    (
        .ref_clk          (ref_clk),
        .sys_rst          (sys_rst),
        .irq_sel          (irq_sel),
        .pen_touch_irq    (pen_touch_irq),
        .result_ready_irq (result_ready_irq),
        .irq_pin          (general_pin_one)
    );

    AST_STOP_IDLE: assert property (@(posedge ref_clk) disable iff (sys_rst) // R18
        stop_req && scan_busy |=> !scan_busy)
        else $error("Stop did not halt the sequencer");
    AST_NONE_IDLE: assert property (@(posedge ref_clk) disable iff (sys_rst) // R3
        mode == `MODE_NONE && !scan_busy |=> !scan_busy)
        else $error("No-scan mode started a sequence");
    AST_HOST_ONLY: assert property (@(posedge ref_clk) disable iff (sys_rst) // R1
        !scan_busy && !trig_pen && !host_start |=> !scan_busy)
        else $error("Host mode started without a command");
    AST_PEN_LIFT: assert property (@(posedge ref_clk) disable iff (sys_rst) // R4
        scan_busy && touch_mode && !pen_sync_q |=> !scan_busy)
        else $error("Touch scan outlived pen lift");
    AST_READY: assert property (@(posedge ref_clk) disable iff (sys_rst) // R19
        state_q == ST_CONV && conv_done && !abort |=> result_ready_irq)
        else $error("Result ready missing");
    AST_IRQ_PEN: assert property (@(posedge ref_clk) disable iff (sys_rst) // R16
        irq_sel == `IRQ_SEL_PEN && $stable(ctrl_q) |=> general_pin_one == !$past(pen_sync_q))
        else $error("Pen irq polarity wrong");
    AST_IRQ_BOTH: assert property (@(posedge ref_clk) disable iff (sys_rst) // R17
        irq_sel == `IRQ_SEL_BOTH && $stable(ctrl_q) && result_ready_irq |=> general_pin_one)
        else $error("Combined irq not high");
    AST_PORT_FIRST: assert property (@(posedge ref_clk) disable iff (sys_rst) // R13
        mode == `MODE_PORT && conv_start && $past(step_q) == 3'h0 |-> conv_channel == CH_AUX_INPUT_ONE)
        else $error("Port scan did not start with aux one");

endmodule : touch_sar_conversion_control

/* File: test/sar_converter_model.sv */
`timescale 1ns/100ps
// Converter stand-in: answers each start alternately fast and slow
module sar_converter_model
(
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    input  wire logic conv_start,
    input  wire logic sar_power_on,
    output logic      conv_done
);
    logic [3:0] wait_q;
    logic       busy_q;
    logic       slow_q;

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            busy_q    <= 1'b0;
            wait_q    <= 4'h0;
            slow_q    <= 1'b0;
            conv_done <= 1'b0;
        end
        else
        begin
            conv_done <= 1'b0;
            if (!sar_power_on)
                busy_q <= 1'b0;
            else if (conv_start)
            begin
                busy_q <= 1'b1;
                wait_q <= slow_q ? 4'h6 : 4'h1;
                slow_q <= ~slow_q;
            end
            else if (busy_q && wait_q == 4'h0)
            begin
                conv_done <= 1'b1;
                busy_q    <= 1'b0;
            end
            else if (busy_q)
                wait_q <= wait_q - 4'h1;
        end
    end
endmodule : sar_converter_model

/* File: test/touch_sar_conversion_control_bench.sv */
`timescale 1ns/100ps
module touch_sar_conversion_control_bench;
    typedef struct { logic [7:0] w; int n; logic [15:0] ch; int how; } row_t;
    logic       ref_clk, sys_rst, reg_wr, host_start, stop_req, pen_down_pin, done_q;
    logic [7:0] reg_wdata, reg_rdata;
    logic [2:0] auto_enable;
    logic       conv_start, conv_done, sar_power_on, result_ready_irq;
    logic       pen_touch_irq, scan_busy, general_pin_one;
    logic [3:0] conv_channel;
    logic [3:0] q[$];
    int         mismatches, cmp_count, k, t;
    // End: 0 by itself, 1 stop, 2 pen lift, 3 mode rewrite
    row_t rows[14] = '{
        '{8'h00, 0, 16'h0000, 0},
        '{8'h05, 4, 16'h0101, 1},
        '{8'h0A, 4, 16'h0123, 1},
        '{8'h8C, 2, 16'h0000, 2},
        '{8'h90, 2, 16'h1111, 2},
        '{8'h94, 4, 16'h2323, 2},
        '{8'h19, 1, 16'h4000, 0},
        '{8'h1C, 1, 16'h6000, 0},
        '{8'h26, 4, 16'h5454, 3},
        '{8'h28, 1, 16'h7000, 0},
        '{8'h2C, 3, 16'h5640, 0},
        '{8'h30, 1, 16'h8000, 0},
        '{8'h98, 0, 16'h0000, 0},
        '{8'h0C, 0, 16'h0000, 0}
    };

    touch_sar_conversion_control touch_sar_conversion_control_inst (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .host_start(host_start), .stop_req(stop_req),
        .auto_enable(auto_enable), .pen_down_pin(pen_down_pin), .conv_start(conv_start),
        .conv_channel(conv_channel), .conv_done(conv_done), .sar_power_on(sar_power_on),
        .result_ready_irq(result_ready_irq), .pen_touch_irq(pen_touch_irq),
        .scan_busy(scan_busy), .general_pin_one(general_pin_one));

    sar_converter_model sar_converter_model_inst (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .conv_start(conv_start),
        .sar_power_on(sar_power_on), .conv_done(conv_done));

    task check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : print_verdict

    task wr(input logic [7:0] d);
        @(negedge ref_clk);
        reg_wdata = d & 8'hBF;
        reg_wr = 1'b1;
        @(negedge ref_clk);
        reg_wr = 1'b0;
    endtask : wr

    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge ref_clk);
        s = 1'b0;
    endtask : pulse

    always @(posedge ref_clk)
    begin
        if (conv_start)
            q.push_back(conv_channel);
        if (done_q)
            check(result_ready_irq, 1'b1);
        // A result that meets stop, a mode rewrite or pen lift in a touch mode is dropped
        done_q <= conv_done && scan_busy && !sys_rst && !stop_req && !reg_wr &&
                  (pen_touch_irq || !(reg_rdata[5:2] inside {[1:5]}));
    end

    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    initial
    begin
        #2000000;
        mismatches++;
        print_verdict();
    end

    initial
    begin
        {sys_rst, reg_wr, host_start, stop_req, pen_down_pin} = 5'b10000;
        reg_wdata = 8'h00;
        auto_enable = 3'b101;
        repeat (4) @(negedge ref_clk);
        sys_rst = 1'b0;
        for (k = 0; k < 14; k++)
        begin
            wr(rows[k].w);
            check(reg_rdata, rows[k].w);
            pen_down_pin = rows[k].w[5:2] inside {[1:5]};
            repeat (3) @(negedge ref_clk);
            pulse(host_start);
            for (t = 0; t < 300 && q.size() < rows[k].n; t++)
                @(negedge ref_clk);
            if (rows[k].n > 0)
                check(sar_power_on, 1'b1);
            case (rows[k].how)
                1: pulse(stop_req);
                2: pen_down_pin = 1'b0;
                3: wr(8'h00);
                default: ;
            endcase
            repeat (20) @(negedge ref_clk);
            check(scan_busy, 1'b0);
            check(sar_power_on, 1'b0);
            if (rows[k].how == 0)
                check(16'(q.size()), 16'(rows[k].n));
            for (t = 0; t < rows[k].n; t++)
                check(q[t], rows[k].ch[15 - 4 * t -: 4]);
            q.delete();
            pen_down_pin = 1'b0;
            repeat (4) @(negedge ref_clk);
        end
        // Pin polarity per select code, pen held and released
        for (k = 0; k < 8; k++)
        begin
            wr({6'h00, k[2:1]});
            pen_down_pin = k[0];
            repeat (4) @(negedge ref_clk);
            check(pen_touch_irq, k[0]);
            check(general_pin_one, k[2:1] == 0 ? !k[0] : (k[2:1] == 2 ? k[0] : 1'b1));
        end
        pen_down_pin = 1'b0;
        // Start and stop together: stop wins
        wr(8'h18);
        host_start = 1'b1;
        pulse(stop_req);
        host_start = 1'b0;
        repeat (10) @(negedge ref_clk);
        check(16'(q.size()), 16'h0000);
        // Reset in the middle of a scan
        wr(8'h05);
        pen_down_pin = 1'b1;
        repeat (3) @(negedge ref_clk);
        pulse(host_start);
        repeat (3) @(negedge ref_clk);
        pulse(sys_rst);
        check(reg_rdata, 8'h00);
        check(general_pin_one, 1'b1);
        check(scan_busy, 1'b0);
        print_verdict();
    end
endmodule : touch_sar_conversion_control_bench
